// >>> design/rcl_cfg_lock.sv
`timescale 1ns/1ps

module rcl_cfg_lock
    import rcl_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire rcl_cfg_req_type cfgReq,
    output logic [7:0]           cfgRdData,
    output logic                 cfgRdValid,
    input  wire rcl_io_req_type  ioReq,
    output logic                 ioHit,
    output logic [7:0]           ioRdData,
    output logic                 ioRdValid,
    output logic                 rtcActive,
    output logic [7:0]           irqSelect,
    output logic [7:0]           irqType,
    output logic [7:0]           ramLock,
    output logic [6:0]           dayAlarmOffset,
    output logic [6:0]           monthAlarmOffset,
    output logic [6:0]           centuryOffset
);

    // ------------------------------------------------------------------
    // Configuration registers.
    // ------------------------------------------------------------------
    logic [7:0] activate_r;
    logic [7:0] activate_nxt;

    // Base pairs; bit 0 of a low byte stays 0.
    logic [7:0] base0High_r;
    logic [7:0] base0High_nxt;

    logic [7:0] base0Low_r;
    logic [7:0] base0Low_nxt;

    logic [7:0] base1High_r;
    logic [7:0] base1High_nxt;

    logic [7:0] base1Low_r;
    logic [7:0] base1Low_nxt;

    logic [7:0] irqSelect_r;
    logic [7:0] irqSelect_nxt;

    logic [7:0] irqType_r;
    logic [7:0] irqType_nxt;

    logic [7:0] ramLock_r;
    logic [7:0] ramLock_nxt;

    logic [7:0] dayOffset_r;
    logic [7:0] dayOffset_nxt;

    logic [7:0] monthOffset_r;
    logic [7:0] monthOffset_nxt;

    logic [7:0] centOffset_r;
    logic [7:0] centOffset_nxt;

    logic [7:0] cfgRdData_r;
    logic [7:0] cfgRdData_nxt;

    logic       cfgRdValid_r;
    logic       cfgRdValid_nxt;

    // Register writes; each field keeps only its writable bits.
    // Taken even while inactive, else activate could never be set.
    always_comb begin
        activate_nxt    = activate_r;
        base0High_nxt   = base0High_r;
        base0Low_nxt    = base0Low_r;
        base1High_nxt   = base1High_r;
        base1Low_nxt    = base1Low_r;
        irqSelect_nxt   = irqSelect_r;
        irqType_nxt     = irqType_r;
        ramLock_nxt     = ramLock_r;
        dayOffset_nxt   = dayOffset_r;
        monthOffset_nxt = monthOffset_r;
        centOffset_nxt  = centOffset_r;
        if (cfgReq.wr) begin
            unique case (cfgReq.idx)
                RCL_IDX_ACTIVATE:   activate_nxt  = cfgReq.data;
                RCL_IDX_BASE0_HIGH: base0High_nxt = cfgReq.data;
                RCL_IDX_BASE0_LOW:  base0Low_nxt  = cfgReq.data & RCL_BASE_LOW_MASK;
                RCL_IDX_BASE1_HIGH: base1High_nxt = cfgReq.data;
                RCL_IDX_BASE1_LOW:  base1Low_nxt  = cfgReq.data & RCL_BASE_LOW_MASK;
                RCL_IDX_IRQ_SELECT: irqSelect_nxt = cfgReq.data;
                RCL_IDX_IRQ_TYPE:   irqType_nxt   = cfgReq.data & RCL_IRQ_TYPE_MASK;
                // Write-one-to-set: a zero never clears a lock, reserved bits stay 0.
                RCL_IDX_RAM_LOCK:   ramLock_nxt = ramLock_r
                    | (cfgReq.data & RCL_LOCK_MASK);
                RCL_IDX_DAY_ALARM:  dayOffset_nxt   = cfgReq.data & RCL_OFFSET_MASK;
                RCL_IDX_MONTH_AL:   monthOffset_nxt = cfgReq.data & RCL_OFFSET_MASK;
                RCL_IDX_CENTURY:    centOffset_nxt  = cfgReq.data & RCL_OFFSET_MASK;
                default: ;
            endcase
        end
    end

    // Read-back; the DMA reports are constants and unmapped indexes give 00h.
    always_comb begin
        cfgRdValid_nxt = cfgReq.rd;
        cfgRdData_nxt  = cfgRdData_r;
        if (cfgReq.rd) begin
            unique case (cfgReq.idx)
                RCL_IDX_ACTIVATE:   cfgRdData_nxt = activate_r;
                RCL_IDX_BASE0_HIGH: cfgRdData_nxt = base0High_r;
                RCL_IDX_BASE0_LOW:  cfgRdData_nxt = base0Low_r;
                RCL_IDX_BASE1_HIGH: cfgRdData_nxt = base1High_r;
                RCL_IDX_BASE1_LOW:  cfgRdData_nxt = base1Low_r;
                RCL_IDX_IRQ_SELECT: cfgRdData_nxt = irqSelect_r;
                RCL_IDX_IRQ_TYPE:   cfgRdData_nxt = irqType_r;
                RCL_IDX_DMA0:       cfgRdData_nxt = RCL_DMA_REPORT;
                RCL_IDX_DMA1:       cfgRdData_nxt = RCL_DMA_REPORT;
                RCL_IDX_RAM_LOCK:   cfgRdData_nxt = ramLock_r;
                RCL_IDX_DAY_ALARM:  cfgRdData_nxt = dayOffset_r;
                RCL_IDX_MONTH_AL:   cfgRdData_nxt = monthOffset_r;
                RCL_IDX_CENTURY:    cfgRdData_nxt = centOffset_r;
                default:            cfgRdData_nxt = RCL_UNMAPPED_READ;
            endcase
        end
    end

    // The host domain reset is the only way back to the reset values.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            activate_r    <= RCL_RST_ACTIVATE;
            base0High_r   <= RCL_RST_BASE0_HIGH;
            base0Low_r    <= RCL_RST_BASE0_LOW;
            base1High_r   <= RCL_RST_BASE1_HIGH;
            base1Low_r    <= RCL_RST_BASE1_LOW;
            irqSelect_r   <= RCL_RST_IRQ_SELECT;
            irqType_r     <= RCL_RST_IRQ_TYPE;
            ramLock_r     <= RCL_RST_RAM_LOCK;
            dayOffset_r   <= RCL_RST_OFFSET;
            monthOffset_r <= RCL_RST_OFFSET;
            centOffset_r  <= RCL_RST_OFFSET;
            cfgRdData_r   <= RCL_UNMAPPED_READ;
            cfgRdValid_r  <= 1'b0;
        end else begin
            activate_r    <= activate_nxt;
            base0High_r   <= base0High_nxt;
            base0Low_r    <= base0Low_nxt;
            base1High_r   <= base1High_nxt;
            base1Low_r    <= base1Low_nxt;
            irqSelect_r   <= irqSelect_nxt;
            irqType_r     <= irqType_nxt;
            ramLock_r     <= ramLock_nxt;
            dayOffset_r   <= dayOffset_nxt;
            monthOffset_r <= monthOffset_nxt;
            centOffset_r  <= centOffset_nxt;
            cfgRdData_r   <= cfgRdData_nxt;
            cfgRdValid_r  <= cfgRdValid_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Run-time index/data decode.
    // ------------------------------------------------------------------
    logic            active;

    logic [15:0]     base0;
    logic [15:0]     base1;

    // Port hits, gated by activate.
    logic            hitStdIdx;
    logic            hitStdDat;
    logic            hitExtIdx;
    logic            hitExtDat;

    logic [6:0]      stdIdx_r;
    logic [6:0]      stdIdx_nxt;

    logic [6:0]      extIdx_r;
    logic [6:0]      extIdx_nxt;

    logic [7:0]      idxRdData_r;
    logic [7:0]      idxRdData_nxt;

    logic            idxRdValid_r;
    logic            idxRdValid_nxt;

    // Lock filter input and output.
    rcl_ram_req_type ramReq;
    rcl_ram_req_type ramGated;

    logic            ramRdBlock;
    logic [7:0]      ramRdData;
    logic            ramRdValid;

    // Ports follow the programmed bases; odd addresses are the data ports.
    // The match is exact, so a base moves both of its ports.
    always_comb begin
        active    = activate_r[RCL_ACTIVATE_BIT];
        base0     = {base0High_r, base0Low_r};
        base1     = {base1High_r, base1Low_r};
        hitStdIdx = active && (ioReq.addr == base0);
        hitStdDat = active && (ioReq.addr == (base0 | 16'h0001));
        hitExtIdx = active && (ioReq.addr == base1);
        hitExtDat = active && (ioReq.addr == (base1 | 16'h0001));
        ioHit     = (ioReq.rd || ioReq.wr)
                  && (hitStdIdx || hitStdDat || hitExtIdx || hitExtDat);
    end

    // Index latches and their read-back; bit 7 of an index reads zero.
    always_comb begin
        stdIdx_nxt     = stdIdx_r;
        extIdx_nxt     = extIdx_r;
        idxRdValid_nxt = ioReq.rd && (hitStdIdx || hitExtIdx);
        idxRdData_nxt  = idxRdData_r;
        if (ioReq.wr && hitStdIdx) begin
            stdIdx_nxt = ioReq.data[6:0];
        end
        if (ioReq.wr && hitExtIdx) begin
            extIdx_nxt = ioReq.data[6:0];
        end
        if (ioReq.rd && hitStdIdx) begin
            idxRdData_nxt = {1'b0, stdIdx_r};
        end else if (ioReq.rd && hitExtIdx) begin
            idxRdData_nxt = {1'b0, extIdx_r};
        end
    end

    // Index latches restart at zero; the RAM keeps its bytes.
    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            stdIdx_r     <= 7'h00;
            extIdx_r     <= 7'h00;
            idxRdData_r  <= RCL_UNMAPPED_READ;
            idxRdValid_r <= 1'b0;
        end else begin
            stdIdx_r     <= stdIdx_nxt;
            extIdx_r     <= extIdx_nxt;
            idxRdData_r  <= idxRdData_nxt;
            idxRdValid_r <= idxRdValid_nxt;
        end
    end

    // Data port access; base1 reaches the extended bank.
    // If both pairs share an address, the standard bank takes the port;
    // the extended bank is then out of reach until a base moves.
    always_comb begin
        ramReq.rd   = ioReq.rd && (hitStdDat || hitExtDat);
        ramReq.wr   = ioReq.wr && (hitStdDat || hitExtDat);
        ramReq.ext  = hitExtDat && !hitStdDat;
        ramReq.idx  = ramReq.ext ? extIdx_r : stdIdx_r;
        ramReq.data = ioReq.data;
    end

    // Lock filtering sits between decode and storage.
    // The guard is pure logic, so a new lock acts on the next access.
    rcl_ram_guard uGuard (
        .reqIn   (ramReq),
        .lock    (ramLock_r),
        .reqOut  (ramGated),
        .rdBlock (ramRdBlock)
    );

    // Storage and read register of both banks.
    rcl_ram_bank uBank (
        .clk_sys (clk_sys),
        .rst_n   (rst_n),
        .req     (ramGated),
        .rdBlock (ramRdBlock),
        .rdData  (ramRdData),
        .rdValid (ramRdValid)
    );

    // ------------------------------------------------------------------
    // Outputs; both read answers come one cycle after the strobe.
    // ------------------------------------------------------------------
    assign cfgRdData        = cfgRdData_r;
    assign cfgRdValid       = cfgRdValid_r;

    assign ioRdData         = idxRdValid_r ? idxRdData_r : ramRdData;
    assign ioRdValid        = idxRdValid_r || ramRdValid;

    // Register values for the clock core.
    assign rtcActive        = active;

    assign irqSelect        = irqSelect_r;
    assign irqType          = irqType_r;
    assign ramLock          = ramLock_r;

    assign dayAlarmOffset   = dayOffset_r[6:0];
    assign monthAlarmOffset = monthOffset_r[6:0];
    assign centuryOffset    = centOffset_r[6:0];

endmodule : rcl_cfg_lock

// >>> design/rcl_ram_bank.sv
`timescale 1ns/1ps

module rcl_ram_bank
    import rcl_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            rst_n,
    input  wire rcl_ram_req_type req,
    input  wire logic            rdBlock,
    output logic [7:0]           rdData,
    output logic                 rdValid
);

    // Battery-backed contents are never cleared by the host reset.
    logic [7:0] stdMem [RCL_RAM_BYTES];
    logic [7:0] extMem [RCL_RAM_BYTES];
    logic [7:0] rdData_r;
    logic [7:0] rdData_nxt;
    logic       rdValid_r;
    logic       rdValid_nxt;

    // Read path; a blocked read returns all ones instead of the byte.
    always_comb begin
        rdValid_nxt = req.rd;
        rdData_nxt  = rdData_r;
        if (req.rd) begin
            if (rdBlock) begin
                rdData_nxt = RCL_BLOCKED_READ;
            end else if (req.ext) begin
                rdData_nxt = extMem[req.idx];
            end else begin
                rdData_nxt = stdMem[req.idx];
            end
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!rst_n) begin
            rdData_r  <= RCL_UNMAPPED_READ;
            rdValid_r <= 1'b0;
        end else begin
            rdData_r  <= rdData_nxt;
            rdValid_r <= rdValid_nxt;
        end
    end

    // Storage write; the guard has already removed locked writes.
    always_ff @(posedge clk_sys) begin
        if (req.wr && req.ext) begin
            extMem[req.idx] <= req.data;
        end
        if (req.wr && !req.ext) begin
            stdMem[req.idx] <= req.data;
        end
    end

    assign rdData  = rdData_r;
    assign rdValid = rdValid_r;

endmodule : rcl_ram_bank

// >>> design/rcl_ram_guard.sv
`timescale 1ns/1ps

module rcl_ram_guard
    import rcl_pkg::*;
(
    input  wire rcl_ram_req_type reqIn,
    input  wire logic [7:0]      lock,
    output rcl_ram_req_type      reqOut,
    output logic                 rdBlock
);

    // True when an index lies inside an inclusive range.
    function automatic logic inRange(input logic [6:0] idx,
                                     input logic [6:0] first,
                                     input logic [6:0] last);
        inRange = (idx >= first) && (idx <= last);
    endfunction : inRange

    logic stdHigh;
    logic extLow;
    logic wrBlock;

    // Lock decode; a blocked write is dropped here so the bank never sees it.
    always_comb begin
        stdHigh = !reqIn.ext && inRange(reqIn.idx, RCL_STD_HIGH_FIRST, RCL_STD_HIGH_LAST);
        extLow  = reqIn.ext && inRange(reqIn.idx, RCL_EXT_LOW_FIRST, RCL_EXT_LOW_LAST);
        wrBlock = lock[RCL_LOCK_ALL_WR]
                | (reqIn.ext && lock[RCL_LOCK_EXT_ALL])
                | (extLow && lock[RCL_LOCK_EXT_WR])
                | (stdHigh && lock[RCL_LOCK_STD_HIGH]);
        rdBlock = (reqIn.ext && lock[RCL_LOCK_EXT_ALL])
                | (extLow && lock[RCL_LOCK_EXT_RD])
                | (stdHigh && lock[RCL_LOCK_STD_HIGH]);
        reqOut    = reqIn;
        reqOut.wr = reqIn.wr && !wrBlock;
    end

endmodule : rcl_ram_guard

// >>> dv/rcl_cfg_lock_sva.sv
`timescale 1ns/1ps

module rcl_cfg_lock_sva
    import rcl_pkg::*;
(
    input wire logic            clk_sys,
    input wire logic            rst_n,
    input wire rcl_cfg_req_type cfgReq,
    input wire logic [7:0]      cfgRdData,
    input wire logic            cfgRdValid,
    input wire rcl_io_req_type  ioReq,
    input wire logic            ioHit,
    input wire logic [7:0]      ioRdData,
    input wire logic            ioRdValid,
    input wire logic            rtcActive,
    input wire logic [7:0]      irqSelect,
    input wire logic [7:0]      irqType,
    input wire logic [7:0]      ramLock,
    input wire logic [6:0]      dayAlarmOffset,
    input wire logic [6:0]      monthAlarmOffset,
    input wire logic [6:0]      centuryOffset
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    // A configuration write to one index, the cause of most register updates.
    sequence s_cfg_wr(logic [7:0] idx);
        cfgReq.wr && cfgReq.idx == idx;
    endsequence

    // A read of either fixed DMA report.
    sequence s_dma_rd;
        cfgReq.rd && (cfgReq.idx == RCL_IDX_DMA0 || cfgReq.idx == RCL_IDX_DMA1);
    endsequence

    // Register updates land exactly one cycle after the write is taken.
    AST_ACT_WR: assert property (s_cfg_wr(RCL_IDX_ACTIVATE) |=>
        rtcActive == $past(cfgReq.data[0])) else $error("activate not updated");
    AST_NO_HIT: assert property (!rtcActive |-> !ioHit)
        else $error("port hit while inactive");
    AST_IRQ_SEL: assert property (s_cfg_wr(RCL_IDX_IRQ_SELECT) |=>
        irqSelect == $past(cfgReq.data)) else $error("irq select not updated");
    AST_IRQ_TYPE: assert property (s_cfg_wr(RCL_IDX_IRQ_TYPE) |=>
        irqType == {6'h00, $past(cfgReq.data[1]), 1'b0}) else $error("irq type wrong");
    AST_DMA: assert property (s_dma_rd |=> cfgRdValid && cfgRdData == 8'h04)
        else $error("dma report wrong");
    // Lock bits only ever gain ones between resets; a missing OR shows here.
    AST_LOCK_SET: assert property (s_cfg_wr(RCL_IDX_RAM_LOCK) |=>
        ramLock == ($past(ramLock) | ($past(cfgReq.data) & 8'hF8))) else $error("lock set wrong");
    AST_LOCK_KEEP: assert property (ramLock != 8'h00 |=>
        ($past(ramLock) & ~ramLock) == 8'h00) else $error("lock bit cleared");
    AST_LOCK_RSVD: assert property (ramLock[2:0] == 3'h0)
        else $error("reserved lock bit set");
    AST_CENTURY: assert property (s_cfg_wr(RCL_IDX_CENTURY) |=>
        centuryOffset == $past(cfgReq.data[6:0])) else $error("century offset wrong");
    AST_DAY: assert property (s_cfg_wr(RCL_IDX_DAY_ALARM) |=>
        dayAlarmOffset == $past(cfgReq.data[6:0])) else $error("day offset wrong");
    AST_MONTH: assert property (s_cfg_wr(RCL_IDX_MONTH_AL) |=>
        monthAlarmOffset == $past(cfgReq.data[6:0])) else $error("month offset wrong");
    AST_IO_RD: assert property (ioReq.rd && ioHit |=> ioRdValid)
        else $error("no read answer on hit");
endmodule : rcl_cfg_lock_sva

bind rcl_cfg_lock rcl_cfg_lock_sva u_rcl_cfg_lock_sva (.clk_sys, .rst_n, .cfgReq,
    .cfgRdData, .cfgRdValid, .ioReq, .ioHit, .ioRdData, .ioRdValid, .rtcActive,
    .irqSelect, .irqType, .ramLock, .dayAlarmOffset, .monthAlarmOffset, .centuryOffset);

// >>> dv/rcl_cfg_lock_tb.sv
`timescale 1ns/1ps

module rcl_cfg_lock_tb
    import rcl_pkg::*;
();
    localparam logic WR = 1'b1;
    localparam logic RD = 1'b0;
    localparam logic EXT = 1'b1;
    localparam logic STD = 1'b0;

    logic            clk_sys = 1'b0;
    logic            rst_n = 1'b0;
    rcl_cfg_req_type cfgReq;
    rcl_io_req_type  ioReq;
    logic [7:0]      cfgRdData, ioRdData, irqSelect, irqType, ramLock, rd;
    logic            cfgRdValid, ioHit, ioRdValid, rtcActive, hit;
    logic [6:0]      dayAlarmOffset, monthAlarmOffset, centuryOffset;
    logic [15:0]     stdBase = 16'h0070;
    int              badCount = 0;
    int              checks = 0;

    rcl_cfg_lock u_rcl_cfg_lock (.clk_sys, .rst_n, .cfgReq, .cfgRdData, .cfgRdValid, .ioReq,
        .ioHit, .ioRdData, .ioRdValid, .rtcActive, .irqSelect, .irqType, .ramLock,
        .dayAlarmOffset, .monthAlarmOffset, .centuryOffset);
    rcl_host_model u_rcl_host_model (.clk_sys, .cfgReq, .ioReq, .cfgRdData, .cfgRdValid,
        .ioHit, .ioRdData, .ioRdValid);

    // Free-running system clock, 20 ns period.
    always #10 clk_sys = ~clk_sys;

    // Case equality, so an unknown never passes for a match.
    task automatic check(input logic [7:0] seen, input logic [7:0] want);
        checks++;
        if (seen !== want) begin
            badCount++;
            $display("BAD %0t seen %h expected %h", $time, seen, want);
        end
    endtask : check

    // Config read compared, and a write followed by its read-back.
    task automatic rchk(input logic [7:0] idx, input logic [7:0] want);
        u_rcl_host_model.cfg_acc(RD, idx, 8'h00, rd);
        check(rd, want);
    endtask : rchk
    task automatic wchk(input logic [7:0] idx, input logic [7:0] d, input logic [7:0] want);
        u_rcl_host_model.cfg_acc(WR, idx, d, rd);
        rchk(idx, want);
    endtask : wchk

    // Hit flag of a data-port read at one address.
    task automatic hit_chk(input logic [15:0] addr, input logic want);
        u_rcl_host_model.io_acc(RD, addr, 8'h00, hit, rd);
        check({7'h00, hit}, {7'h00, want});
    endtask : hit_chk

    // One RAM byte through the bank's index/data pair; a read is compared.
    task automatic ram(input logic wr, input logic ext, input logic [6:0] a, input logic [7:0] d);
        logic [15:0] base;
        base = ext ? 16'h0072 : stdBase;
        u_rcl_host_model.io_acc(WR, base, {1'b0, a}, hit, rd);
        u_rcl_host_model.io_acc(wr, base | 16'h0001, d, hit, rd);
        if (!wr) begin
            check(rd, d);
        end
    endtask : ram

    // Reset value of every register, plus one unmapped index.
    task automatic t_reset_values();
        logic [7:0] idx [14] = '{8'h30, 8'h60, 8'h61, 8'h62, 8'h63, 8'h70, 8'h71, 8'h74,
                                 8'h75, 8'hF0, 8'hF1, 8'hF2, 8'hF3, 8'h40};
        logic [7:0] want [14] = '{8'h00, 8'h00, 8'h70, 8'h00, 8'h72, 8'h08, 8'h00, 8'h04,
                                  8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};
        for (int i = 0; i < 14; i++) begin
            rchk(idx[i], want[i]);
        end
    endtask : t_reset_values

    // Writable masks; the standard bank is moved so decode follows the new base.
    task automatic t_cfg_writes();
        wchk(RCL_IDX_DAY_ALARM, 8'hFF, 8'h7F);
        wchk(RCL_IDX_MONTH_AL, 8'hAA, 8'h2A);
        wchk(RCL_IDX_CENTURY, 8'h15, 8'h15);
        wchk(RCL_IDX_IRQ_SELECT, 8'hA5, 8'hA5);
        wchk(RCL_IDX_IRQ_TYPE, 8'hFF, 8'h02);
        wchk(RCL_IDX_DMA1, 8'h00, 8'h04);
        wchk(RCL_IDX_BASE0_HIGH, 8'h01, 8'h01);
        wchk(RCL_IDX_BASE0_LOW, 8'h71, 8'h70);
        stdBase = 16'h0170;
    endtask : t_cfg_writes

    // No decode while inactive; afterwards only at the programmed base.
    task automatic t_activate();
        hit_chk(16'h0073, 1'b0);
        wchk(RCL_IDX_ACTIVATE, 8'h01, 8'h01);
        hit_chk(16'h0071, 1'b0);
        hit_chk(16'h0171, 1'b1);
    endtask : t_activate

    // Locks are set one at a time, since none can be undone before reset.
    task automatic t_locks();
        ram(WR, EXT, 7'h05, 8'h11);
        ram(WR, EXT, 7'h20, 8'h22);
        ram(WR, STD, 7'h37, 8'h44);
        ram(RD, EXT, 7'h05, 8'h11);
        wchk(RCL_IDX_RAM_LOCK, 8'h27, 8'h20);
        ram(WR, EXT, 7'h05, 8'h55);
        ram(WR, EXT, 7'h20, 8'h66);
        ram(RD, EXT, 7'h05, 8'h11);
        ram(RD, EXT, 7'h20, 8'h66);
        wchk(RCL_IDX_RAM_LOCK, 8'h80, 8'hA0);
        ram(RD, STD, 7'h3F, 8'hFF);
        ram(RD, STD, 7'h37, 8'h44);
        wchk(RCL_IDX_RAM_LOCK, 8'h10, 8'hB0);
        ram(RD, EXT, 7'h1F, 8'hFF);
        ram(RD, EXT, 7'h20, 8'h66);
        wchk(RCL_IDX_RAM_LOCK, 8'h40, 8'hF0);
        ram(WR, STD, 7'h37, 8'h99);
        ram(WR, EXT, 7'h20, 8'h99);
        ram(RD, STD, 7'h37, 8'h44);
        ram(RD, EXT, 7'h20, 8'h66);
        wchk(RCL_IDX_RAM_LOCK, 8'h08, 8'hF8);
        ram(RD, EXT, 7'h20, 8'hFF);
        wchk(RCL_IDX_RAM_LOCK, 8'h00, 8'hF8);
        u_rcl_host_model.io_acc(RD, 16'h0072, 8'h00, hit, rd);
        check(rd, 8'h20);
    endtask : t_locks

    // A reset in mid-run is the only thing that clears the locks.
    task automatic t_second_reset();
        @(posedge clk_sys);
        #1;
        rst_n = 1'b0;
        repeat (2) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        rchk(RCL_IDX_RAM_LOCK, 8'h00);
        rchk(RCL_IDX_ACTIVATE, 8'h00);
    endtask : t_second_reset

    task automatic test_done();
        $display("checks %0d mismatches %0d", checks, badCount);
        if (badCount == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : test_done

    // Main sequence after a 12-cycle reset.
    initial begin
        repeat (12) @(posedge clk_sys);
        #1;
        rst_n = 1'b1;
        t_reset_values();
        t_cfg_writes();
        t_activate();
        t_locks();
        t_second_reset();
        test_done();
    end

    // The run needs under two hundred cycles, so this only trips on a hang.
    initial begin
        repeat (20000) @(posedge clk_sys);
        badCount++;
        test_done();
    end
endmodule : rcl_cfg_lock_tb

// >>> dv/rcl_host_model.sv
`timescale 1ns/1ps

module rcl_host_model
    import rcl_pkg::*;
(
    input  wire logic       clk_sys,
    output rcl_cfg_req_type cfgReq,
    output rcl_io_req_type  ioReq,
    input  wire logic [7:0] cfgRdData,
    input  wire logic       cfgRdValid,
    input  wire logic       ioHit,
    input  wire logic [7:0] ioRdData,
    input  wire logic       ioRdValid
);
    // Both buses start idle so nothing is taken during reset.
    initial begin
        cfgReq = '0;
        ioReq  = '0;
    end

    // One config access per call; the leading edge keeps strobes apart, and the
    // released lines are scrambled because the host no longer holds them.
    task automatic cfg_acc(input logic wr, input logic [7:0] idx, input logic [7:0] wdata,
                           output logic [7:0] rdata);
        @(posedge clk_sys);
        #1;
        cfgReq = '{~wr, wr, idx, wdata};
        @(posedge clk_sys);
        #1;
        cfgReq = '{1'b0, 1'b0, ~idx, ~wdata};
        rdata = cfgRdValid === 1'b1 ? cfgRdData : 8'hXX;
    endtask : cfg_acc

    // One host I/O cycle; the hit flag is sampled before the taking edge.
    task automatic io_acc(input logic wr, input logic [15:0] addr, input logic [7:0] wdata,
                          output logic hit, output logic [7:0] rdata);
        @(posedge clk_sys);
        #1;
        ioReq = '{~wr, wr, addr, wdata};
        #1;
        hit = ioHit;
        @(posedge clk_sys);
        #1;
        ioReq = '{1'b0, 1'b0, ~addr, ~wdata};
        rdata = ioRdValid === 1'b1 ? ioRdData : 8'hXX;
    endtask : io_acc
endmodule : rcl_host_model

// >>> pkg/rcl_pkg.sv
package rcl_pkg;

    // ------------------------------------------------------------------
    // Configuration register indexes of the clock logical device.
    // ------------------------------------------------------------------
    localparam logic [7:0] RCL_IDX_ACTIVATE   = 8'h30;
    localparam logic [7:0] RCL_IDX_BASE0_HIGH = 8'h60;
    localparam logic [7:0] RCL_IDX_BASE0_LOW  = 8'h61;
    localparam logic [7:0] RCL_IDX_BASE1_HIGH = 8'h62;
    localparam logic [7:0] RCL_IDX_BASE1_LOW  = 8'h63;
    localparam logic [7:0] RCL_IDX_IRQ_SELECT = 8'h70;
    localparam logic [7:0] RCL_IDX_IRQ_TYPE   = 8'h71;
    localparam logic [7:0] RCL_IDX_DMA0       = 8'h74;
    localparam logic [7:0] RCL_IDX_DMA1       = 8'h75;
    localparam logic [7:0] RCL_IDX_RAM_LOCK   = 8'hF0;
    localparam logic [7:0] RCL_IDX_DAY_ALARM  = 8'hF1;
    localparam logic [7:0] RCL_IDX_MONTH_AL   = 8'hF2;
    localparam logic [7:0] RCL_IDX_CENTURY    = 8'hF3;

    // ------------------------------------------------------------------
    // Reset values and fixed read values.
    // ------------------------------------------------------------------
    localparam logic [7:0] RCL_RST_ACTIVATE   = 8'h00;
    localparam logic [7:0] RCL_RST_BASE0_HIGH = 8'h00;
    localparam logic [7:0] RCL_RST_BASE0_LOW  = 8'h70;
    localparam logic [7:0] RCL_RST_BASE1_HIGH = 8'h00;
    localparam logic [7:0] RCL_RST_BASE1_LOW  = 8'h72;
    localparam logic [7:0] RCL_RST_IRQ_SELECT = 8'h08;
    localparam logic [7:0] RCL_RST_IRQ_TYPE   = 8'h00;
    localparam logic [7:0] RCL_RST_RAM_LOCK   = 8'h00;
    localparam logic [7:0] RCL_RST_OFFSET     = 8'h00;
    localparam logic [7:0] RCL_DMA_REPORT     = 8'h04;
    localparam logic [7:0] RCL_BLOCKED_READ   = 8'hFF;
    localparam logic [7:0] RCL_UNMAPPED_READ  = 8'h00;

    // ------------------------------------------------------------------
    // Field positions and writable masks.
    // ------------------------------------------------------------------
    localparam int         RCL_ACTIVATE_BIT   = 0;
    localparam logic [7:0] RCL_BASE_LOW_MASK  = 8'hFE;
    localparam logic [7:0] RCL_IRQ_TYPE_MASK  = 8'h02;
    localparam logic [7:0] RCL_LOCK_MASK      = 8'hF8;
    localparam logic [7:0] RCL_OFFSET_MASK    = 8'h7F;
    localparam int         RCL_LOCK_EXT_ALL   = 3;
    localparam int         RCL_LOCK_EXT_RD    = 4;
    localparam int         RCL_LOCK_EXT_WR    = 5;
    localparam int         RCL_LOCK_ALL_WR    = 6;
    localparam int         RCL_LOCK_STD_HIGH  = 7;

    // ------------------------------------------------------------------
    // Guarded byte ranges inside the two RAM banks.
    // ------------------------------------------------------------------
    localparam logic [6:0] RCL_EXT_LOW_FIRST  = 7'h00;
    localparam logic [6:0] RCL_EXT_LOW_LAST   = 7'h1F;
    localparam logic [6:0] RCL_STD_HIGH_FIRST = 7'h38;
    localparam logic [6:0] RCL_STD_HIGH_LAST  = 7'h3F;
    localparam int         RCL_RAM_BYTES      = 128;

    // Configuration access as seen behind the index/data mechanism.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic [7:0] idx;
        logic [7:0] data;
    } rcl_cfg_req_type;

    // Host I/O cycle decoded from the bus.
    typedef struct packed {
        logic        rd;
        logic        wr;
        logic [15:0] addr;
        logic [7:0]  data;
    } rcl_io_req_type;

    // Access to one byte of clock RAM.
    typedef struct packed {
        logic       rd;
        logic       wr;
        logic       ext;
        logic [6:0] idx;
        logic [7:0] data;
    } rcl_ram_req_type;

endpackage : rcl_pkg
